//--- verilog/crs_cfg.svh
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH
// Address of the target select register
`define CRS_SEL_ADDR 8'hff
// Reset value of the target select register
`define CRS_SEL_RST 8'h00
// Field positions inside the select register
`define CRS_BCAST_BIT 3
`define CRS_CHEN_BIT 2
`define CRS_IDX_HI 1
`define CRS_IDX_LO 0
// Value returned on a read of the select address
`define CRS_SEL_RD_VAL 8'h00
// Number of channels
`define CRS_NCH 4
`endif

//--- verilog/crs_pkg.sv
package crs_pkg;
  // Destination class of an access
  typedef enum logic [1:0] {
    CRS_TGT_SHARED,
    CRS_TGT_CHAN,
    CRS_TGT_SELECT
  } crs_target_t;
endpackage

//--- verilog/crs_select.sv
`timescale 1ns/1ps
`include "crs_cfg.svh"
module crs_select #(
  parameter int NCH = `CRS_NCH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] shared_rdata,
  input wire logic [7:0] chan_rdata [NCH],
  input wire logic [7:0] ro_mask,
  output logic shared_wr,
  output logic shared_rd,
  output logic [NCH-1:0] chan_wr,
  output logic [NCH-1:0] chan_rd,
  output logic [7:0] tgt_addr,
  output logic [7:0] tgt_wdata,
  output logic [7:0] acc_rdata,
  output logic acc_rvalid,
  output logic [7:0] select_value,
  output crs_pkg::crs_target_t last_target
);
  import crs_pkg::*;

  logic [7:0] sel_q;
  logic [7:0] sel_d;
  logic [NCH-1:0] cwr_d;
  logic [NCH-1:0] crd_d;
  logic [7:0] rdata_d;
  crs_target_t tgt_d;

  // Decode of the select fields
  wire logic is_sel = (acc_addr == `CRS_SEL_ADDR);
  wire logic chen = sel_q[`CRS_CHEN_BIT];
  wire logic bcast = sel_q[`CRS_BCAST_BIT];
  wire logic [1:0] idx = sel_q[`CRS_IDX_HI:`CRS_IDX_LO];
  // Address 0xff never reaches a channel bank, enable or not
  wire logic to_chan = chen && !is_sel;
  wire logic to_shared = !chen && !is_sel;
  // Read-only shared registers drop writes here so banks need no guard
  wire logic ro_hit = ro_mask[0] && to_shared;
  wire logic sel_wr = acc_wr && is_sel;

  // Upper bits are stored as written; host keeps them zero
  assign sel_d = sel_wr ? acc_wdata : sel_q;

  // Per-channel strobes; broadcast only widens writes, never reads
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign cwr_d[g] = acc_wr && to_chan && (bcast || idx == 2'(g));
      assign crd_d[g] = acc_rd && to_chan && idx == 2'(g);
    end
  endgenerate

  // Read data: select address reads back a fixed meaningless byte
  assign rdata_d = is_sel ? `CRS_SEL_RD_VAL :
                   chen ? chan_rdata[idx] : shared_rdata;
  assign tgt_d = is_sel ? CRS_TGT_SELECT : (chen ? CRS_TGT_CHAN : CRS_TGT_SHARED);

  // Select register; reset leaves the shared set as target
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sel_q <= `CRS_SEL_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  // Registered strobes toward the register sets
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shared_wr <= 1'b0;
      shared_rd <= 1'b0;
      chan_wr <= '0;
      chan_rd <= '0;
      tgt_addr <= 8'h00;
      tgt_wdata <= 8'h00;
    end else begin
      shared_wr <= acc_wr && to_shared && !ro_hit;
      shared_rd <= acc_rd && to_shared;
      chan_wr <= cwr_d;
      chan_rd <= crd_d;
      tgt_addr <= acc_addr;
      tgt_wdata <= acc_wdata;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc_rdata <= 8'h00;
      acc_rvalid <= 1'b0;
      last_target <= CRS_TGT_SHARED;
    end else begin
      acc_rvalid <= acc_rd;
      if (acc_rd) begin
        acc_rdata <= rdata_d;
      end
      if (acc_rd || acc_wr) begin
        last_target <= tgt_d;
      end
    end
  end

  assign select_value = sel_q;

  // Broadcast write reaches every bank
  bcast_all_a: assert property (@(posedge ref_clk) disable iff (srst)
    acc_wr && chen && bcast && !is_sel |=> chan_wr == '1)
    else $error("broadcast write missed a channel");
  // Channel read strobes exactly one bank
  rd_one_a: assert property (@(posedge ref_clk) disable iff (srst)
    acc_rd && chen && !is_sel |=> $onehot(chan_rd))
    else $error("channel read not one-hot");
  // Disabled enable keeps banks idle
  shared_only_a: assert property (@(posedge ref_clk) disable iff (srst)
    (acc_rd || acc_wr) && !chen |=> chan_wr == '0 && chan_rd == '0)
    else $error("channel bank hit while disabled");
  // Enabled access never strobes shared set
  chan_route_a: assert property (@(posedge ref_clk) disable iff (srst)
    (acc_rd || acc_wr) && chen |=> !shared_wr && !shared_rd)
    else $error("shared set hit while enabled");
  // Select write always lands in select
  sel_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    acc_wr && is_sel |=> sel_q == $past(acc_wdata))
    else $error("select write lost");
  // Address 0xff never strobes a bank
  no_ff_chan_a: assert property (@(posedge ref_clk) disable iff (srst)
    is_sel |=> chan_wr == '0 && chan_rd == '0 && !shared_wr)
    else $error("bank decoded at select address");
  // Select holds without a select write
  sel_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !sel_wr |=> $stable(sel_q))
    else $error("select changed without write");
  // Unicast write hits the indexed bank only
  uni_wr_a: assert property (@(posedge ref_clk) disable iff (srst)
    acc_wr && chen && !bcast && !is_sel |=> chan_wr == (NCH'(1) << $past(idx)))
    else $error("unicast write wrong bank");
  // Reset returns select to zero
  sel_reset_a: assert property (@(posedge ref_clk)
    srst |=> sel_q == `CRS_SEL_RST)
    else $error("select not cleared by reset");

  // Named steps of an access, kept apart so each check reads as a trace
  sequence chan_rd_s;
    acc_rd && chen && !is_sel;
  endsequence
  sequence shared_rd_s;
    acc_rd && !chen && !is_sel;
  endsequence
  sequence shared_wr_s;
    acc_wr && !chen && !is_sel;
  endsequence
  sequence sel_rd_s;
    acc_rd && is_sel;
  endsequence

  // Broadcast never widens a read beyond the indexed bank
  bcast_rd_a: assert property (@(posedge ref_clk) disable iff (srst)
    chan_rd_s ##0 bcast |=> chan_rd == (NCH'(1) << $past(idx)))
    else $error("broadcast read hit wrong bank");
  // Channel read returns the indexed bank's byte
  chan_data_a: assert property (@(posedge ref_clk) disable iff (srst)
    chan_rd_s |=> acc_rvalid && acc_rdata == $past(chan_rdata[idx]))
    else $error("channel read data wrong");
  // Shared read strobes the shared set and returns its byte
  shared_rd_a: assert property (@(posedge ref_clk) disable iff (srst)
    shared_rd_s |=> shared_rd && acc_rdata == $past(shared_rdata))
    else $error("shared read data wrong");
  // Read-only shared register keeps its contents
  ro_drop_a: assert property (@(posedge ref_clk) disable iff (srst)
    shared_wr_s ##0 ro_mask[0] |=> !shared_wr)
    else $error("write reached read-only register");
  // Writable shared register gets its strobe
  shared_wr_a: assert property (@(posedge ref_clk) disable iff (srst)
    shared_wr_s ##0 !ro_mask[0] |=> shared_wr)
    else $error("shared write dropped");
  // Select read gives the fixed byte and touches no set
  sel_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    sel_rd_s |=> acc_rvalid && acc_rdata == `CRS_SEL_RD_VAL && chan_rd == '0 && !shared_rd)
    else $error("select read not isolated");
  // Address and data reach the sets unchanged
  tgt_copy_a: assert property (@(posedge ref_clk) disable iff (srst)
    (acc_wr || acc_rd) |=> tgt_addr == $past(acc_addr) && tgt_wdata == $past(acc_wdata))
    else $error("target address or data wrong");
  // Select access is classed as such
  sel_tgt_a: assert property (@(posedge ref_clk) disable iff (srst)
    (acc_wr || acc_rd) && is_sel |=> last_target == CRS_TGT_SELECT)
    else $error("select access class wrong");
  // Enabled access outside the select address is classed as a channel access
  chan_tgt_a: assert property (@(posedge ref_clk) disable iff (srst)
    (acc_wr || acc_rd) && chen && !is_sel |=> last_target == CRS_TGT_CHAN)
    else $error("channel access class wrong");
  // An answer only ever follows a read
  rvalid_only_a: assert property (@(posedge ref_clk) disable iff (srst)
    !acc_rd |=> !acc_rvalid)
    else $error("read answer without read");
  // Read data stands until the next read
  rdata_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !acc_rd |=> $stable(acc_rdata))
    else $error("read data changed without read");
endmodule // crs_select

//--- sim/crs_host.sv
`timescale 1ns/1ps
// Management bus host: one access per falling edge, back to back allowed
module crs_host (
  input wire logic ref_clk,
  output logic acc_wr,
  output logic acc_rd,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata
);
  initial begin
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_addr = 8'h00;
    acc_wdata = 8'h00;
  end
  // Select byte is always sent whole with a zero upper nibble
  task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    acc_wr = w;
    acc_rd = !w;
    acc_addr = a;
    acc_wdata = (a == 8'hff) ? {4'h0, d[3:0]} : d;
  endtask
  // Released address lines show an inverted value, never the stale address; write data stays as it was
  task automatic idle;
    @(negedge ref_clk);
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_addr = ~acc_addr;
  endtask
endmodule // crs_host

//--- sim/channel_register_select_tb.sv
`timescale 1ns/1ps
module channel_register_select_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic acc_wr, acc_rd, shared_wr, shared_rd, acc_rvalid;
  logic [7:0] acc_addr, acc_wdata, shared_rdata, ro_mask, acc_rdata, select_value, sel, a;
  logic [7:0] chan_rdata [4];
  logic [3:0] chan_wr, chan_rd;
  logic [7:0] tgt_addr, tgt_wdata;
  crs_pkg::crs_target_t last_target;
  // Note = {target class, address, data, strobes, read answer}
  logic [36:0] q [$];
  logic [36:0] got;
  logic [7:0] vals [9] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
  int bad_count = 0, check_count = 0, cyc = 0, seed = 32'hcdf9;
  always #25 ref_clk = ~ref_clk;
  // Bank data is a plain function of address so expectations need no lookup
  assign shared_rdata = acc_addr ^ 8'h5a;
  for (genvar n = 0; n < 4; n++) begin : g_bank
    assign chan_rdata[n] = acc_addr ^ (8'h10 << n);
  end
  assign ro_mask = {7'h00, acc_addr == 8'h01};
  crs_host host_u (.ref_clk(ref_clk), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata));
  crs_select dut_u (.ref_clk(ref_clk), .srst(srst), .acc_wr(acc_wr), .acc_rd(acc_rd),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .shared_rdata(shared_rdata),
    .chan_rdata(chan_rdata), .ro_mask(ro_mask), .shared_wr(shared_wr), .shared_rd(shared_rd),
    .chan_wr(chan_wr), .chan_rd(chan_rd), .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .select_value(select_value),
    .last_target(last_target));
  // Note the expected result, then hand the access to the host
  task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] dt);
    logic [3:0] hit;
    logic [17:0] hd;
    hit = 4'h1 << sel[1:0];
    hd = {sel[2] ? crs_pkg::CRS_TGT_CHAN : crs_pkg::CRS_TGT_SHARED, ad, dt};
    if (ad == 8'hff) begin
      if (!w) begin
        q.push_back({crs_pkg::CRS_TGT_SELECT, ad, dt, 19'h0_0100});
      end
    end else if (sel[2] && w) begin
      q.push_back({hd, 2'b00, sel[3] ? 4'hf : hit, 13'h0000});
    end else if (sel[2]) begin
      q.push_back({hd, 6'h00, hit, 1'b1, ad ^ (8'h10 << sel[1:0])});
    end else if (w && ad != 8'h01) begin
      q.push_back({hd, 2'b10, 17'h0_0000});
    end else if (!w) begin
      q.push_back({hd, 2'b01, 8'h00, 1'b1, ad ^ 8'h5a});
    end
    if (w && ad == 8'hff) sel = {4'h0, dt[3:0]};
    host_u.req(w, ad, dt);
  endtask
  // Select must read back zero after every reset
  task automatic chk_sel;
    check_count++;
    if (select_value !== 8'h00) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, select_value, 8'h00);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Any strobe or read answer takes the oldest note; a surplus result misses
  always @(negedge ref_clk) begin
    got = {last_target, tgt_addr, tgt_wdata, shared_wr, shared_rd, chan_wr, chan_rd,
      acc_rvalid, acc_rvalid ? acc_rdata : 8'h00};
    if (!srst && got[18:0] !== 19'h0_0000) begin
      check_count++;
      if (q.size() == 0 || got !== q[0]) begin
        bad_count++;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, q.size() ? q[0] : 37'h00_0000_0000);
      end
      if (q.size()) void'(q.pop_front());
    end
  end
  // Run takes about 66 cycles; the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 2000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    sel = 8'h00;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk) srst = 1'b0;
    chk_sel();
    acc(1'b1, 8'h01, 8'h33);
    foreach (vals[i]) begin
      a = {1'b0, 7'($random(seed))};
      acc(1'b1, 8'hff, vals[i]);
      acc(1'b1, a, 8'($random(seed)));
      acc(1'b0, a, 8'h00);
      acc(1'b0, 8'hff, 8'h00);
      acc(1'b1, 8'h00, 8'h5c);
      $display("test select %h done", vals[i]);
    end
    host_u.idle();
    // Mid-run reset must drop the target back to the shared set
    @(negedge ref_clk) srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    sel = 8'h00;
    chk_sel();
    acc(1'b0, 8'h02, 8'h00);
    $display("test reset done");
    host_u.idle();
    repeat (3) @(negedge ref_clk);
    bad_count += q.size();
    summarize();
  end
endmodule // channel_register_select_tb
